// ===== hdl/cpu_pkg.sv
`default_nettype none
package cpu_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------
  // opcodes and opcode fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PREFIX = 8'h9E;
  localparam logic [7:0] OP_TRAP   = 8'h83;
  localparam logic [7:0] OP_TRET   = 8'h80;
  localparam logic [7:0] OP_WAIT   = 8'h8F;
  localparam logic [7:0] OP_STOP   = 8'h8E;
  localparam logic [7:0] OP_SP_ADD = 8'hA7;
  localparam logic [7:0] OP_HX_ADD = 8'hAF;
  localparam logic [7:0] OP_BR_CC  = 8'h24;
  localparam logic [7:0] OP_BR_CS  = 8'h25;
  localparam logic [7:0] OP_BR_ZS  = 8'h27;
  localparam logic [7:0] OP_ADD_IM = 8'hAB;
  localparam logic [7:0] OP_AND_IM = 8'hA4;
  localparam logic [3:0] LO_ADC    = 4'h9;
  localparam logic [3:0] LO_ADD    = 4'hB;
  localparam logic [3:0] LO_AND    = 4'h4;
  localparam logic [3:0] LO_ASL    = 4'h8;
  localparam logic [3:0] LO_ASR    = 4'h7;

  // ---------------------------------------------------------------
  // vectors, reset values, condition code layout
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_BREAK     = 16'hFFFC;
  localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
  localparam logic [15:0] SP_RESET      = 16'h00FF;
  localparam logic [7:0]  CCR_RESET     = 8'h68;
  localparam logic [7:0]  CCR_ONES      = 8'h60;
  localparam int          CCR_V         = 7;
  localparam int          CCR_H         = 4;
  localparam int          CCR_I         = 3;
  localparam int          CCR_N         = 2;
  localparam int          CCR_Z         = 1;
  localparam int          CCR_C         = 0;
  localparam logic [2:0]  PUSH_LAST     = 3'h4;
  localparam int          OSC_DELAY_DEFAULT = 4096;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [9:0] {
    S_FETCH = 10'h001, S_OPND = 10'h002, S_READ = 10'h004,
    S_WRITE = 10'h008, S_PAD  = 10'h010, S_PUSH = 10'h020,
    S_VECT  = 10'h040, S_PULL = 10'h080, S_SLEEP = 10'h100,
    S_WAKE  = 10'h200
  } state_t;

  typedef enum logic [3:0] {
    M_INH = 4'h0, M_IMM = 4'h1, M_DIR = 4'h2, M_EXT = 4'h3, M_IX2 = 4'h4,
    M_IX1 = 4'h5, M_IX  = 4'h6, M_SP1 = 4'h7, M_SP2 = 4'h8, M_REL = 4'h9
  } amode_t;

  typedef enum logic [3:0] {
    C_NOP = 4'h0, C_ALU = 4'h1, C_SHIFT = 4'h2, C_SPADD = 4'h3,
    C_HXADD = 4'h4, C_BR = 4'h5, C_BITCLR = 4'h6, C_TRAP = 4'h7,
    C_TRET = 4'h8, C_WAIT = 4'h9,
    C_STOP = 4'hA
  } iclass_t;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0, ALU_ADD = 3'h1, ALU_ADC = 3'h2, ALU_AND = 3'h3,
    ALU_ASL  = 3'h4, ALU_ASR = 3'h5
  } aluop_t;

  typedef struct packed {
    iclass_t cls;
    amode_t  mode;
    aluop_t  op;
  } dec_t;
endpackage
`default_nettype wire

// ===== hdl/cpu_alu.sv
`default_nettype none
module cpu_alu (
  input  wire cpu_pkg::aluop_t op,
  input  wire logic [7:0]      a,
  input  wire logic [7:0]      m,
  input  wire logic [7:0]      ccr_in,
  output logic [7:0]           res,
  output logic [7:0]           ccr_out
);
  import cpu_pkg::*;

  logic [8:0] sum9;
  logic [4:0] sum5;
  logic       cin;

  always_comb begin
    cin  = (op == ALU_ADC) ? ccr_in[CCR_C] : 1'b0;
    sum9 = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    sum5 = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    res     = a;
    ccr_out = ccr_in;
    // interrupt mask is never touched here
    case (op)
      ALU_ADD, ALU_ADC: begin
        res            = sum9[7:0];
        ccr_out[CCR_V] = (a[7] == m[7]) && (sum9[7] != a[7]);
        ccr_out[CCR_H] = sum5[4];
        ccr_out[CCR_C] = sum9[8];
      end
      ALU_AND: begin
        res            = a & m;
        ccr_out[CCR_V] = 1'b0;
      end
      ALU_ASL: begin
        res            = {a[6:0], 1'b0};
        ccr_out[CCR_C] = a[7];
        ccr_out[CCR_V] = a[7] ^ a[6];
      end
      ALU_ASR: begin
        res            = {a[7], a[7:1]};
        ccr_out[CCR_C] = a[0];
        ccr_out[CCR_V] = a[7] ^ a[0];
      end
      default: res = a;
    endcase
    if (op != ALU_PASS) begin
      ccr_out[CCR_N] = res[7];
      ccr_out[CCR_Z] = (res == 8'h00);
    end
  end
endmodule
`default_nettype wire

// ===== hdl/cpu_core.sv
// Notes on behaviour
// - idle standby clears mask; reset sets it
// - deep sleep clears mask; reset sets it
// - both standby instructions then stop clock
// - deep-sleep exit waits oscillator delay first
// - break loads trap opcode, vector by mode
// - break starts at instruction boundary only
// - trap return ends break if request gone
// - alu performs all defined arithmetic, logic
// - stack pointer add immediate, two cycles
// - index pair add immediate, two cycles
// - branch on carry clear, three cycles
// - branch on carry set, three cycles
// - branch on zero set, three cycles
`default_nettype none
module cpu_core #(
  parameter int OSC_DELAY_CYC = cpu_pkg::OSC_DELAY_DEFAULT
) (
  input  wire logic                         CLK,
  input  wire logic                         SYS_RST,
  input  wire logic [cpu_pkg::DATA_W-1:0]   MEM_RDATA,
  input  wire logic                         INT_REQ,
  input  wire logic                         INT_EXT,
  input  wire logic [cpu_pkg::ADDR_W-1:0]   INT_VEC_ADDR,
  input  wire logic                         BRK_REQ,
  input  wire logic                         MONITOR_MODE,
  output logic      [cpu_pkg::ADDR_W-1:0]   BUS_ADDR,
  output logic      [cpu_pkg::DATA_W-1:0]   BUS_WDATA,
  output logic                              BUS_WR,
  output logic                              CPU_CLK_RUN,
  output logic                              IDLE_MODE,
  output logic                              DEEP_SLEEP,
  output logic                              BREAK_ACTIVE
);
  import cpu_pkg::*;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  function automatic logic [2:0] nbytes(input amode_t md);
    case (md)
      M_EXT, M_IX2, M_SP2: return 3'h2;
      M_IX, M_INH:         return 3'h0;
      default:             return 3'h1;
    endcase
  endfunction

  function automatic dec_t decode(input logic [7:0] op, input logic pre);
    dec_t       d;
    logic [3:0] hi;
    logic [3:0] lo;
    d  = '{C_NOP, M_INH, ALU_PASS};
    hi = op[7:4];
    lo = op[3:0];
    if (!pre && hi == 4'h1 && op[0]) begin
      d.cls  = C_BITCLR;
      d.mode = M_DIR;
    end else if ((lo == LO_ADC || lo == LO_ADD || lo == LO_AND) &&
                 (pre ? (hi == 4'hE || hi == 4'hD) : hi >= 4'hA)) begin
      d.cls = C_ALU;
      d.op  = (lo == LO_ADC) ? ALU_ADC : (lo == LO_ADD) ? ALU_ADD : ALU_AND;
      case (hi)
        4'hA:    d.mode = M_IMM;
        4'hB:    d.mode = M_DIR;
        4'hC:    d.mode = M_EXT;
        4'hD:    d.mode = pre ? M_SP2 : M_IX2;
        4'hE:    d.mode = pre ? M_SP1 : M_IX1;
        default: d.mode = M_IX;
      endcase
    end else if ((lo == LO_ASL || lo == LO_ASR) &&
                 (pre ? hi == 4'h6 : (hi >= 4'h3 && hi <= 4'h7))) begin
      d.cls = C_SHIFT;
      d.op  = (lo == LO_ASL) ? ALU_ASL : ALU_ASR;
      case (hi)
        4'h3:    d.mode = M_DIR;
        4'h6:    d.mode = pre ? M_SP1 : M_IX1;
        4'h7:    d.mode = M_IX;
        default: d.mode = M_INH;
      endcase
    end else if (!pre) begin
      case (op)
        OP_TRAP:   d.cls = C_TRAP;
        OP_TRET:   d.cls = C_TRET;
        OP_WAIT:   d.cls = C_WAIT;
        OP_STOP:   d.cls = C_STOP;
        OP_SP_ADD: d = '{C_SPADD, M_IMM, ALU_PASS};
        OP_HX_ADD: d = '{C_HXADD, M_IMM, ALU_PASS};
        OP_BR_CC, OP_BR_CS, OP_BR_ZS: d = '{C_BR, M_REL, ALU_PASS};
        default: d.cls = C_NOP;
      endcase
    end
    return d;
  endfunction

  // pushed in this order: pc low, pc high, x, a, ccr
  function automatic logic [7:0] stack_byte(input logic [2:0]  idx,
                                            input logic [15:0] pc,
                                            input logic [7:0]  x,
                                            input logic [7:0]  acc,
                                            input logic [7:0]  ccr);
    case (idx)
      3'h0:    return pc[7:0];
      3'h1:    return pc[15:8];
      3'h2:    return x;
      3'h3:    return acc;
      default: return ccr;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t      state_q, state_d;
  dec_t        dec_q,   dec_d,  fdec;
  logic [15:0] addr_q,  addr_d, pc_q, pc_d, sp_q, sp_d, hx_q, hx_d;
  logic [15:0] ea_q,    ea_d,   vec_q, vec_d, wake_q, wake_d;
  logic [7:0]  wdata_q, wdata_d, a_q, a_d, ccr_q, ccr_d, ir_q, ir_d;
  logic [2:0]  cnt_q,   cnt_d;
  logic        wr_q, wr_d, pre_q, pre_d, brk_q, brk_d, run_q, run_d;
  logic        idle_q, idle_d, deep_q, deep_d;
  logic        done, push, br_take;
  logic [15:0] push_vec, brk_vec, eff_addr, base;
  aluop_t      alu_op;
  logic [7:0]  alu_a, alu_res, alu_ccr;

  cpu_alu u_alu (
    .op      (alu_op),
    .a       (alu_a),
    .m       (MEM_RDATA),
    .ccr_in  (ccr_q),
    .res     (alu_res),
    .ccr_out (alu_ccr)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;  dec_d = dec_q;   addr_d = addr_q;  pc_d = pc_q;
    sp_d    = sp_q;     hx_d  = hx_q;    ea_d   = ea_q;    vec_d = vec_q;
    wake_d  = wake_q;   wdata_d = wdata_q; a_d  = a_q;     ccr_d = ccr_q;
    ir_d    = ir_q;     cnt_d = cnt_q;   wr_d   = 1'b0;    pre_d = pre_q;
    brk_d   = brk_q;    idle_d = idle_q; deep_d = deep_q;
    done = 1'b0;
    push = 1'b0;
    alu_op = dec_q.op;
    alu_a  = a_q;
    fdec   = decode(MEM_RDATA, pre_q);
    brk_vec  = MONITOR_MODE ? VEC_BREAK_MON : VEC_BREAK;
    push_vec = brk_vec;
    base = (dec_q.mode == M_DIR || dec_q.mode == M_EXT) ? 16'h0000 :
           (dec_q.mode == M_SP1 || dec_q.mode == M_SP2) ? sp_q : hx_q;
    eff_addr = base + {(nbytes(dec_q.mode) == 3'h2) ? ea_q[7:0] : 8'h00,
                       MEM_RDATA};
    case (ir_q)
      OP_BR_CC: br_take = !ccr_q[CCR_C];
      OP_BR_CS: br_take = ccr_q[CCR_C];
      default: br_take = ccr_q[CCR_Z];
    endcase
    case (state_q)
      S_FETCH: begin
        pc_d   = pc_q + 16'h0001;
        addr_d = pc_q + 16'h0001;
        if (MEM_RDATA == OP_PREFIX && !pre_q) begin
          pre_d = 1'b1;
        end else begin
          pre_d = 1'b0;
          ir_d  = MEM_RDATA;
          dec_d = fdec;
          case (fdec.cls)
            C_TRAP: push = 1'b1;
            C_TRET: begin
              state_d = S_PULL;
              sp_d    = sp_q + 16'h0001;
              addr_d  = sp_q + 16'h0001;
              cnt_d   = 3'h0;
            end
            C_WAIT, C_STOP: begin
              ccr_d[CCR_I] = 1'b0;
              state_d = S_SLEEP;
              idle_d  = (fdec.cls == C_WAIT);
              deep_d  = (fdec.cls == C_STOP);
            end
            C_NOP: done = 1'b1;
            default: begin
              if (fdec.mode == M_INH) begin
                alu_op = fdec.op;
                alu_a  = MEM_RDATA[4] ? hx_q[7:0] : a_q;
                if (MEM_RDATA[4]) hx_d[7:0] = alu_res;
                else a_d = alu_res;
                ccr_d = alu_ccr;
                done  = 1'b1;
              end else if (fdec.mode == M_IX) begin
                ea_d    = hx_q;
                addr_d  = hx_q;
                state_d = S_READ;
              end else begin
                cnt_d   = nbytes(fdec.mode);
                state_d = S_OPND;
              end
            end
          endcase
        end
      end
      S_OPND: begin
        pc_d   = pc_q + 16'h0001;
        addr_d = pc_q + 16'h0001;
        ea_d   = {ea_q[7:0], MEM_RDATA};
        cnt_d  = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          if (dec_q.cls == C_SPADD) begin
            sp_d = sp_q + sext(MEM_RDATA);
            done = 1'b1;
          end else if (dec_q.cls == C_HXADD) begin
            hx_d = hx_q + sext(MEM_RDATA);
            done = 1'b1;
          end else if (dec_q.cls == C_BR) begin
            // target is opcode address + 2 + rel
            if (br_take) pc_d = pc_q + 16'h0001 + sext(MEM_RDATA);
            state_d = S_PAD;
          end else if (dec_q.mode == M_IMM) begin
            a_d   = alu_res;
            ccr_d = alu_ccr;
            done  = 1'b1;
          end else begin
            ea_d    = eff_addr;
            addr_d  = eff_addr;
            state_d = S_READ;
          end
        end
      end
      S_PAD: done = 1'b1;
      S_READ: begin
        case (dec_q.cls)
          C_ALU: begin
            a_d   = alu_res;
            ccr_d = alu_ccr;
            done  = 1'b1;
          end
          C_SHIFT: begin
            alu_a   = MEM_RDATA;
            wdata_d = alu_res;
            ccr_d   = alu_ccr;
            wr_d    = 1'b1;
            state_d = S_WRITE;
          end
          C_BITCLR: begin
            wdata_d = MEM_RDATA & ~(8'h01 << ir_q[3:1]);
            wr_d    = 1'b1;
            state_d = S_WRITE;
          end
          default: done = 1'b1;
        endcase
      end
      S_WRITE: done = 1'b1;
      S_PUSH: begin
        sp_d = sp_q - 16'h0001;
        if (cnt_q != PUSH_LAST) begin
          addr_d  = sp_q - 16'h0001;
          wdata_d = stack_byte(cnt_q + 3'h1, pc_q, hx_q[7:0], a_q, ccr_q);
          wr_d    = 1'b1;
          cnt_d   = cnt_q + 3'h1;
        end else begin
          // mask set only after the registers are saved
          ccr_d[CCR_I] = 1'b1;
          addr_d  = vec_q;
          cnt_d   = 3'h0;
          state_d = S_VECT;
        end
      end
      S_VECT: begin
        ea_d = {ea_q[7:0], MEM_RDATA};
        if (cnt_q == 3'h0) begin
          addr_d = vec_q + 16'h0001;
          cnt_d  = 3'h1;
        end else begin
          pc_d = {ea_q[7:0], MEM_RDATA};
          done = 1'b1;
        end
      end
      S_PULL: begin
        ea_d = {ea_q[7:0], MEM_RDATA};
        case (cnt_q)
          3'h0:    ccr_d = MEM_RDATA | CCR_ONES;
          3'h1:    a_d = MEM_RDATA;
          3'h2:    hx_d[7:0] = MEM_RDATA;
          default: ea_d = {ea_q[7:0], MEM_RDATA};
        endcase
        if (cnt_q != PUSH_LAST) begin
          sp_d   = sp_q + 16'h0001;
          addr_d = sp_q + 16'h0001;
          cnt_d  = cnt_q + 3'h1;
        end else begin
          pc_d = {ea_q[7:0], MEM_RDATA};
          // break held while the request persists
          if (!BRK_REQ) brk_d = 1'b0;
          done = 1'b1;
        end
      end
      S_SLEEP: begin
        // deep sleep only answers external sources
        if (INT_REQ && idle_q) begin
          push     = 1'b1;
          push_vec = INT_VEC_ADDR;
        end else if (INT_REQ && INT_EXT && deep_q) begin
          wake_d  = 16'h0000;
          state_d = S_WAKE;
        end
      end
      S_WAKE: begin
        // clock held off until oscillator settles
        wake_d = wake_q + 16'h0001;
        if (wake_q == 16'(OSC_DELAY_CYC - 1)) begin
          push     = 1'b1;
          push_vec = INT_VEC_ADDR;
        end
      end
      default: state_d = S_FETCH;
    endcase
    // requests looked at once an instruction ends; the sleep states also take interrupts
    if (done) begin
      if (BRK_REQ && !brk_q) begin
        // trap opcode forced, vector picked by mode
        push  = 1'b1;
        brk_d = 1'b1;
        ir_d  = OP_TRAP;
      end else if (INT_REQ && !ccr_d[CCR_I]) begin
        push     = 1'b1;
        push_vec = INT_VEC_ADDR;
      end else begin
        state_d = S_FETCH;
        addr_d  = pc_d;
      end
    end
    if (push) begin
      state_d = S_PUSH;
      vec_d   = push_vec;
      addr_d  = sp_q;
      wdata_d = pc_d[7:0];
      wr_d    = 1'b1;
      cnt_d   = 3'h0;
      idle_d  = 1'b0;
      deep_d  = 1'b0;
    end
    run_d = (state_d != S_SLEEP) && (state_d != S_WAKE);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= S_VECT;     dec_q <= '{C_NOP, M_INH, ALU_PASS};
      addr_q  <= VEC_RESET;  vec_q <= VEC_RESET;  pc_q <= 16'h0000;
      sp_q    <= SP_RESET;   hx_q  <= 16'h0000;   ea_q <= 16'h0000;
      wake_q  <= 16'h0000;   wdata_q <= 8'h00;    a_q  <= 8'h00;
      ccr_q   <= CCR_RESET;  ir_q  <= 8'h00;      cnt_q <= 3'h0;
      wr_q    <= 1'b0;       pre_q <= 1'b0;       brk_q <= 1'b0;
      run_q   <= 1'b1;       idle_q <= 1'b0;      deep_q <= 1'b0;
    end else begin
      state_q <= state_d;    dec_q <= dec_d;
      addr_q  <= addr_d;     vec_q <= vec_d;      pc_q <= pc_d;
      sp_q    <= sp_d;       hx_q  <= hx_d;       ea_q <= ea_d;
      wake_q  <= wake_d;     wdata_q <= wdata_d;  a_q  <= a_d;
      ccr_q   <= ccr_d;      ir_q  <= ir_d;       cnt_q <= cnt_d;
      wr_q    <= wr_d;       pre_q <= pre_d;      brk_q <= brk_d;
      run_q   <= run_d;      idle_q <= idle_d;    deep_q <= deep_d;
    end
  end

  assign BUS_ADDR     = addr_q;
  assign BUS_WDATA    = wdata_q;
  assign BUS_WR       = wr_q;
  assign CPU_CLK_RUN  = run_q;
  assign IDLE_MODE    = idle_q;
  assign DEEP_SLEEP   = deep_q;
  assign BREAK_ACTIVE = brk_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_fetch(logic [7:0] op);
    state_q == S_FETCH && !pre_q && MEM_RDATA == op;
  endsequence
  sequence s_branch_steps;
    state_q == S_OPND ##1 state_q == S_PAD;
  endsequence

  property p_branch(logic [7:0] op, logic cond);
    (s_fetch(op) and cond) |=> s_branch_steps ##1
      (ccr_q == $past(ccr_q, 3) && (state_q != S_FETCH ||
       BUS_ADDR == $past(pc_q, 3) + 16'h0002 + sext($past(MEM_RDATA, 2))));
  endproperty

  a_wait_mask:
  assert property (s_fetch(OP_WAIT) |=>
    !ccr_q[CCR_I] && !CPU_CLK_RUN && IDLE_MODE)
    else $error("idle entry left mask set or clock running");
  a_stop_mask:
  assert property (s_fetch(OP_STOP) |=>
    !ccr_q[CCR_I] && !CPU_CLK_RUN && DEEP_SLEEP && !BUS_WR)
    else $error("deep sleep entry wrong");
  a_sleep_quiet:
  assert property (state_q == S_SLEEP |-> !CPU_CLK_RUN && !BUS_WR)
    else $error("bus active with clock stopped");
  a_wake_hold:
  assert property ((state_q == S_WAKE &&
                    wake_q != 16'(OSC_DELAY_CYC - 1)) |=>
                   state_q == S_WAKE && !CPU_CLK_RUN)
    else $error("woke before oscillator delay");
  a_break_entry:
  assert property ($rose(brk_q) |-> state_q == S_PUSH && ir_q == OP_TRAP &&
    vec_q == ($past(MONITOR_MODE) ? VEC_BREAK_MON : VEC_BREAK))
    else $error("break entry vector or opcode wrong");
  a_break_boundary:
  assert property ($rose(brk_q) |-> $past(done) && BUS_WR)
    else $error("break taken inside an instruction");
  a_rti_break:
  assert property ((state_q == S_PULL && cnt_q == PUSH_LAST && brk_q) |=>
                   brk_q == $past(BRK_REQ))
    else $error("trap return mishandled break state");
  a_add_imm:
  assert property (s_fetch(OP_ADD_IM) |=> state_q == S_OPND ##1
    (a_q == $past(a_q) + $past(MEM_RDATA) &&
     ccr_q[CCR_Z] == (a_q == 8'h00) && ccr_q[CCR_N] == a_q[7] &&
     ccr_q[CCR_I] == $past(ccr_q[CCR_I], 2)))
    else $error("add immediate result or flags wrong");
  a_sp_add:
  assert property (s_fetch(OP_SP_ADD) |=> state_q == S_OPND ##1
    (sp_q == $past(sp_q) + sext($past(MEM_RDATA)) &&
     ccr_q == $past(ccr_q, 2) && state_q != S_OPND))
    else $error("stack pointer add wrong");
  a_hx_add:
  assert property (s_fetch(OP_HX_ADD) |=> state_q == S_OPND ##1
    (hx_q == $past(hx_q) + sext($past(MEM_RDATA)) &&
     ccr_q == $past(ccr_q, 2)))
    else $error("index pair add wrong");
  a_cclr_branch:
  assert property (p_branch(OP_BR_CC, !ccr_q[CCR_C]))
    else $error("carry clear branch wrong");
  a_cset_branch:
  assert property (p_branch(OP_BR_CS, ccr_q[CCR_C]))
    else $error("carry set branch wrong");
  a_zero_branch:
  assert property (p_branch(OP_BR_ZS, ccr_q[CCR_Z]))
    else $error("zero branch wrong");
  a_and_flags:
  assert property (s_fetch(OP_AND_IM) |=> state_q == S_OPND ##1
    (a_q == ($past(a_q) & $past(MEM_RDATA)) && !ccr_q[CCR_V]))
    else $error("and result or overflow wrong");
  a_bitclr_write:
  assert property ((state_q == S_READ && dec_q.cls == C_BITCLR) |=>
    (BUS_WR && ccr_q == $past(ccr_q) &&
     BUS_WDATA == ($past(MEM_RDATA) & ~(8'h01 << ir_q[3:1]))))
    else $error("bit clear write wrong");
endmodule
`default_nettype wire

// ===== bench/mem_model.sv
`default_nettype none
module mem_model (
  input  wire logic        CLK,
  input  wire logic [15:0] BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  input  wire logic        BUS_WR,
  output logic      [7:0]  MEM_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  // zero-wait read: the core has no wait states
  assign MEM_RDATA = mem[BUS_ADDR];
  // plain always: the bench preloads this array directly
  always @(posedge CLK) begin
    if (BUS_WR) begin
      mem[BUS_ADDR] <= BUS_WDATA;
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_cpu_lowpower_break_isa_subset.sv
`default_nettype none
module test_cpu_lowpower_break_isa_subset;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, irq, ext, brk, mon, wr, run, idle, deep, bact;
  logic [15:0] vec, addr;
  logic [7:0] rd, wd;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  mem_model u (.CLK(clk), .BUS_ADDR(addr), .BUS_WDATA(wd), .BUS_WR(wr),
    .MEM_RDATA(rd));
  cpu_core #(.OSC_DELAY_CYC(4)) dut (.CLK(clk), .SYS_RST(rst),
    .MEM_RDATA(rd), .INT_REQ(irq), .INT_EXT(ext), .INT_VEC_ADDR(vec),
    .BRK_REQ(brk), .MONITOR_MODE(mon), .BUS_ADDR(addr), .BUS_WDATA(wd),
    .BUS_WR(wr), .CPU_CLK_RUN(run), .IDLE_MODE(idle), .DEEP_SLEEP(deep),
    .BREAK_ACTIVE(bact));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] m(input logic [15:0] a);
    return {8'h00, u.mem[a]};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, well above the whole program's length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // program: adds, carry branches (wrong path stops), pointer adds,
  // bit clear, and, zero branch, idle standby
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] r1, r2, r3, a, ccr;
    logic [8:0] s;
    logic [7:0] p [0:24];
    rst = 1; irq = 0; ext = 0; brk = 0; mon = 0; vec = 16'hFFF0;
    void'($urandom(87247));
    r1 = $urandom;
    r2 = $urandom;
    r3 = $urandom | 1;
    s = {1'b0, r1} + r2;
    a = s[7:0];
    ccr = {3'b011, ({1'b0, r1[3:0]} + r2[3:0]) > 5'h0F, 1'b0, a[7],
      a == 8'h00, s[8]};
    p = '{8'hAB, r1, 8'hAB, r2, 8'h25, 8'h06, 8'h24, 8'h04, 8'h8E, 8'h8E,
      8'h8E, 8'h8E, 8'hA7, 8'hF0, 8'hAF, 8'h05, 8'h11, 8'h80, 8'hA4,
      8'hFF, 8'h27, 8'h02, 8'h8F, 8'h8F, 8'h8F};
    for (int i = 0; i < 65536; i++) u.mem[i] = 8'h9D;
    for (int i = 0; i < 25; i++) u.mem[16'h1000 + i] = p[i];
    u.mem[16'hFFFE] = 8'h10; u.mem[16'hFFFF] = 8'h00;
    u.mem[16'hFFF0] = 8'h20; u.mem[16'hFFF1] = 8'h00;
    u.mem[16'hFEFC] = 8'h30; u.mem[16'hFEFD] = 8'h00;
    u.mem[16'h2001] = 8'h8E; u.mem[16'h3000] = 8'h80;
    u.mem[16'h0080] = r3;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk iff idle); #1;
    check("deep", 16'h0, {15'h0, deep});
    check("run", 16'h0, {15'h0, run});
    check("bitclr", {8'h00, r3 & 8'hFE}, m(16'h0080));
    @(posedge clk); irq <= 1;
    @(posedge clk iff wr); irq <= 0; brk <= 1; mon <= 1;
    @(posedge clk iff bact);
    repeat (4) @(posedge clk); #1;
    check("vec", 16'hFEFC, addr);
    repeat (2) @(posedge clk); #1;
    check("fetch", 16'h3000, addr);
    check("pcl", {8'h10, (a == 8'h00) ? 8'h19 : 8'h17},
      {u.mem[16'h00EE], u.mem[16'h00EF]});
    check("x", 16'h0005, m(16'h00ED));
    check("acc", {8'h00, a}, m(16'h00EC));
    check("ccr", {8'h00, ccr}, m(16'h00EB));
    // break taken at the end of vectoring: stacked pc low is 00
    check("brk_pc", 16'h0000, m(16'h00EA));
    // break request dropped before the trap return finishes
    @(posedge clk); brk <= 0;
    @(posedge clk iff !bact);
    @(posedge clk iff deep); irq <= 1;
    repeat (3) @(posedge clk); #1;
    check("no_ext", 16'h1, {15'h0, deep});
    @(posedge clk); ext <= 1;
    repeat (3) @(posedge clk); #1;
    check("osc", 16'h0, {15'h0, run});
    @(posedge clk iff wr); irq <= 0;
    repeat (5) @(posedge clk); #1;
    check("i_clr", 16'h0, m(16'h00E6) & 16'h0008);
    report_and_stop();
  end
endmodule
`default_nettype wire
